// ===== rtl/register_subword_intr_summary.sv
// Purpose: Interrupt register with summary outputs on classic Wishbone.
// Assumes: 32-bit bus, byte addresses, external window from 0x80 up.
// Notes:   One access at a time; internal registers answer one cycle after the request.
`timescale 1ns/1ns
module register_subword_intr_summary #(
  parameter int unsigned REG_WIDTH    = 32,
  parameter int unsigned ACCESS_WIDTH = REG_WIDTH,
  parameter int unsigned NUM_FIELDS   = 8,
  parameter bit          HIGH_FIRST   = 1'b0,
  parameter bit          HAS_HALT     = 1'b1
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [regblk_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [regblk_pkg::SEL_W-1:0]  sel_i,
  input  wire logic [regblk_pkg::DATA_W-1:0] dat_i,
  output logic      [regblk_pkg::DATA_W-1:0] dat_o,
  output logic                               ack_o,
  output logic                               err_o,
  input  wire logic [NUM_FIELDS-1:0]         event_i,
  output logic                               intr_summary_o,
  output logic                               halt_summary_o,
  output logic                               ext_req_o,
  output logic                               ext_we_o,
  output logic      [regblk_pkg::ADDR_W-1:0] ext_addr_o,
  output logic      [regblk_pkg::SEL_W-1:0]  ext_sel_o,
  output logic      [regblk_pkg::DATA_W-1:0] ext_wdata_o,
  input  wire logic [regblk_pkg::DATA_W-1:0] ext_rdata_i,
  input  wire logic                          ext_ack_i,
  input  wire logic                          ext_err_i
);
  import regblk_pkg::*;

  localparam int unsigned LANES = ACCESS_WIDTH / 8;
  localparam int unsigned NSUB  = DATA_W / ACCESS_WIDTH;

  // ***************************************************************
  // Declarations
  // ***************************************************************
  bus_state_t           state, next_state;
  logic                 wr_q, next_wr, we_q, next_we, resp_err, next_err;
  logic                 ext_start, next_start;
  logic [ADDR_W-1:0]    addr_q, next_addr, word_adr;
  logic [SEL_W-1:0]     sel_q, next_sel;
  logic [DATA_W-1:0]    wdat_q, next_wdat, next_rdata, rd_word, byte_mask;
  logic                 hit, is_ext, sub_ok, write_now;
  logic [NSUB-1:0]      sub_fine;
  logic [REG_WIDTH-1:0] enable, mask, halt_en, halt_mask, status, clr;
  logic [REG_WIDTH-1:0] next_enable, next_mask, next_halt_en;
  logic [REG_WIDTH-1:0] next_halt_mask, wm, wd;
  logic [DATA_W-1:0]    info;

  ext_link_if lnk ();

  // ***************************************************************
  // Address decode and sub-word legality
  // ***************************************************************
  assign word_adr = {adr_i[ADDR_W-1:2], 2'b00};
  assign is_ext   = (word_adr >= OFF_EXT_BASE);

  // A write must cover each sub-word wholly or not at all
  for (genvar g = 0; g < NSUB; g++) begin : g_sub
    assign sub_fine[g] = (&sel_i[g*LANES +: LANES]) ||
                         !(|sel_i[g*LANES +: LANES]);
  end
  assign sub_ok = &sub_fine;

  for (genvar k = 0; k < SEL_W; k++) begin : g_lane
    assign byte_mask[k*8 +: 8] = {8{sel_q[k]}};
  end

  always_comb begin
    info = '0;
    info[INFO_RW_POS +: 8]  = 8'(REG_WIDTH);
    info[INFO_AW_POS +: 8]  = 8'(ACCESS_WIDTH);
    info[INFO_ORDER_POS]    = HIGH_FIRST;
    info[INFO_INTR_POS]     = intr_summary_o;
    info[INFO_HALT_POS]     = halt_summary_o;
    info[INFO_HASH_POS]     = HAS_HALT;
  end

  // Status reads have no side effect, so any lane subset is served
  always_comb begin
    hit     = 1'b1;
    rd_word = '0;
    if (word_adr == OFF_STATUS) begin
      rd_word = DATA_W'(status);
    end else if (word_adr == OFF_ENABLE) begin
      rd_word = DATA_W'(enable);
    end else if (word_adr == OFF_MASK) begin
      rd_word = DATA_W'(mask);
    end else if (HAS_HALT && word_adr == OFF_HALT_EN) begin
      rd_word = DATA_W'(halt_en);
    end else if (HAS_HALT && word_adr == OFF_HALT_MASK) begin
      rd_word = DATA_W'(halt_mask);
    end else if (word_adr == OFF_INFO && !we_i) begin
      rd_word = info;
    end else begin
      hit = 1'b0;
    end
  end

  // ***************************************************************
  // Bus state machine
  // ***************************************************************
  always_comb begin
    next_state = state;
    next_wr    = 1'b0;
    next_we    = we_q;
    next_err   = resp_err;
    next_addr  = addr_q;
    next_sel   = sel_q;
    next_wdat  = wdat_q;
    next_rdata = dat_o;
    next_start = 1'b0;
    case (state)
      ST_IDLE: begin
        if (cyc_i && stb_i) begin
          next_addr = word_adr;
          next_sel  = sel_i;
          next_wdat = dat_i;
          next_we   = we_i;
          if (is_ext) begin
            next_start = 1'b1;
            next_state = ST_EXT;
          end else begin
            next_state = ST_RESP;
            next_rdata = we_i ? '0 : rd_word;
            next_err   = !hit || (we_i && !sub_ok);
            next_wr    = we_i && hit && sub_ok;
          end
        end
      end
      ST_EXT: begin
        if (lnk.done) begin
          next_rdata = lnk.rdata;
          next_err   = lnk.err;
          next_state = ST_RESP;
        end
      end
      ST_RESP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= ST_IDLE;
      wr_q      <= 1'b0;
      we_q      <= 1'b0;
      resp_err  <= 1'b0;
      addr_q    <= '0;
      sel_q     <= '0;
      wdat_q    <= '0;
      dat_o     <= '0;
      ext_start <= 1'b0;
    end else begin
      state     <= next_state;
      wr_q      <= next_wr;
      we_q      <= next_we;
      resp_err  <= next_err;
      addr_q    <= next_addr;
      sel_q     <= next_sel;
      wdat_q    <= next_wdat;
      dat_o     <= next_rdata;
      ext_start <= next_start;
    end
  end

  assign ack_o = (state == ST_RESP) && !resp_err;
  assign err_o = (state == ST_RESP) && resp_err;

  assign lnk.req   = ext_start;
  assign lnk.we    = we_q;
  assign lnk.addr  = addr_q;
  assign lnk.sel   = sel_q;
  assign lnk.wdata = wdat_q;

  // ***************************************************************
  // Control registers
  // ***************************************************************
  // Writes land on the edge where the master sees ack
  assign write_now = (state == ST_RESP) && wr_q;
  assign wm        = byte_mask[REG_WIDTH-1:0];
  assign wd        = wdat_q[REG_WIDTH-1:0];

  always_comb begin
    next_enable    = enable;
    next_mask      = mask;
    next_halt_en   = halt_en;
    next_halt_mask = halt_mask;
    clr            = '0;
    // Unselected sub-words keep their contents
    if (write_now) begin
      if (addr_q == OFF_ENABLE) begin
        next_enable = (enable & ~wm) | (wd & wm);
      end else if (addr_q == OFF_MASK) begin
        next_mask = (mask & ~wm) | (wd & wm);
      end else if (addr_q == OFF_HALT_EN) begin
        next_halt_en = (halt_en & ~wm) | (wd & wm);
      end else if (addr_q == OFF_HALT_MASK) begin
        next_halt_mask = (halt_mask & ~wm) | (wd & wm);
      end else if (addr_q == OFF_STATUS) begin
        clr = wd & wm;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable    <= REG_WIDTH'(RST_CTRL);
      mask      <= REG_WIDTH'(RST_CTRL);
      halt_en   <= REG_WIDTH'(RST_CTRL);
      halt_mask <= REG_WIDTH'(RST_CTRL);
    end else begin
      enable    <= next_enable;
      mask      <= next_mask;
      halt_en   <= next_halt_en;
      halt_mask <= next_halt_mask;
    end
  end

  // ***************************************************************
  // Submodules
  // ***************************************************************
  intr_field_bank #(
    .REG_WIDTH  (REG_WIDTH),
    .NUM_FIELDS (NUM_FIELDS),
    .HIGH_FIRST (HIGH_FIRST),
    .HAS_HALT   (HAS_HALT)
  ) u_bank (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .event_i        (event_i),
    .clr_i          (clr),
    .enable_i       (enable),
    .mask_i         (mask),
    .halt_en_i      (halt_en),
    .halt_mask_i    (halt_mask),
    .status_o       (status),
    .intr_summary_o (intr_summary_o),
    .halt_summary_o (halt_summary_o)
  );

  ext_reg_port u_ext (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .lnk         (lnk.port),
    .ext_req_o   (ext_req_o),
    .ext_we_o    (ext_we_o),
    .ext_addr_o  (ext_addr_o),
    .ext_sel_o   (ext_sel_o),
    .ext_wdata_o (ext_wdata_o),
    .ext_rdata_i (ext_rdata_i),
    .ext_ack_i   (ext_ack_i),
    .ext_err_i   (ext_err_i)
  );

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_reg_width;
    1'b1 |-> (REG_WIDTH >= 8) && (REG_WIDTH <= DATA_W) &&
             ((REG_WIDTH & (REG_WIDTH - 1)) == 0);
  endproperty
  a_reg_width: assert property (p_reg_width)
    else $error("register width is not a legal power of two");

  property p_access_width;
    1'b1 |-> (ACCESS_WIDTH >= 8) && (ACCESS_WIDTH <= REG_WIDTH) &&
             ((ACCESS_WIDTH & (ACCESS_WIDTH - 1)) == 0);
  endproperty
  a_access_width: assert property (p_access_width)
    else $error("access width is illegal");

  property p_partial_refused;
    state == ST_IDLE && cyc_i && stb_i && we_i && !is_ext && !sub_ok
      |=> err_o && !ack_o ##1 !err_o;
  endproperty
  a_partial_refused: assert property (p_partial_refused)
    else $error("write below access width was not refused");

  property p_read_data;
    state == ST_IDLE && cyc_i && stb_i && !we_i && word_adr == OFF_ENABLE
      |=> ack_o && dat_o == DATA_W'($past(enable));
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("enable read returned wrong data");

  property p_keep;
    write_now && addr_q == OFF_MASK
      |=> (mask & ~$past(wm)) == ($past(mask) & ~$past(wm));
  endproperty
  a_keep: assert property (p_keep)
    else $error("sub-word write disturbed another sub-word");

  property p_ext_fold;
    state == ST_EXT && lnk.done && lnk.err |=> err_o && !ack_o;
  endproperty
  a_ext_fold: assert property (p_ext_fold)
    else $error("external error not returned on the bus");

  c_read:  cover property (state == ST_IDLE && stb_i && !we_i ##1 ack_o);
  c_write: cover property (write_now ##0 ack_o);
  c_ext:   cover property (ext_req_o ##[1:20] ack_o);
endmodule

// ===== rtl/regblk_pkg.sv
// Purpose: Shared constants and types of the interrupt register block.
// Assumes: 32-bit classic Wishbone, byte addresses, one clock.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package regblk_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W  = 4;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] OFF_STATUS    = 8'h00;
  localparam logic [7:0] OFF_ENABLE    = 8'h04;
  localparam logic [7:0] OFF_MASK      = 8'h08;
  localparam logic [7:0] OFF_HALT_EN   = 8'h0c;
  localparam logic [7:0] OFF_HALT_MASK = 8'h10;
  localparam logic [7:0] OFF_INFO      = 8'h14;
  localparam logic [7:0] OFF_EXT_BASE  = 8'h80;

  // ***************************************************************
  // Info word fields and reset values
  // ***************************************************************
  localparam int unsigned INFO_RW_POS    = 0;
  localparam int unsigned INFO_AW_POS    = 8;
  localparam int unsigned INFO_ORDER_POS = 16;
  localparam int unsigned INFO_INTR_POS  = 17;
  localparam int unsigned INFO_HALT_POS  = 18;
  localparam int unsigned INFO_HASH_POS  = 19;

  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESP = 3'b010,
    ST_EXT  = 3'b100
  } bus_state_t;

endpackage

// ===== rtl/ext_link_if.sv
// Purpose: Carries one forwarded access to the external register port.
// Assumes: Same clock on both sides.
// Notes:   req is a one-cycle pulse; done is a one-cycle pulse.
`timescale 1ns/1ns
interface ext_link_if;
  logic                          req;
  logic                          we;
  logic [regblk_pkg::ADDR_W-1:0] addr;
  logic [regblk_pkg::SEL_W-1:0]  sel;
  logic [regblk_pkg::DATA_W-1:0] wdata;
  logic                          done;
  logic                          err;
  logic [regblk_pkg::DATA_W-1:0] rdata;

  modport main (output req, we, addr, sel, wdata,
                input  done, err, rdata);
  modport port (input  req, we, addr, sel, wdata,
                output done, err, rdata);
endinterface

// ===== rtl/intr_field_bank.sv
// Purpose: Sticky interrupt fields with enable, mask and halt gating.
// Assumes: Events come from logic on the same clock.
// Notes:   Fields are one bit each, packed by the chosen bit order.
`timescale 1ns/1ns
module intr_field_bank #(
  parameter int unsigned REG_WIDTH  = 32,
  parameter int unsigned NUM_FIELDS = 8,
  parameter bit          HIGH_FIRST = 1'b0,
  parameter bit          HAS_HALT   = 1'b1
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [NUM_FIELDS-1:0] event_i,
  input  wire logic [REG_WIDTH-1:0]  clr_i,
  input  wire logic [REG_WIDTH-1:0]  enable_i,
  input  wire logic [REG_WIDTH-1:0]  mask_i,
  input  wire logic [REG_WIDTH-1:0]  halt_en_i,
  input  wire logic [REG_WIDTH-1:0]  halt_mask_i,
  output logic      [REG_WIDTH-1:0]  status_o,
  output logic                       intr_summary_o,
  output logic                       halt_summary_o
);
  import regblk_pkg::*;

  localparam int unsigned P0 = HIGH_FIRST ? REG_WIDTH - 1 : 0;

  logic [REG_WIDTH-1:0] next_status;

  // ***************************************************************
  // Per-bit field placement
  // ***************************************************************
  // Size-only fields packed end to end from bit 0 or from the top
  // Each field is one bit, its bounds equal, so none straddles
  for (genvar b = 0; b < REG_WIDTH; b++) begin : g_bit
    localparam int unsigned IDX = HIGH_FIRST ? REG_WIDTH - 1 - b : b;
    if (IDX < NUM_FIELDS) begin : g_field
      // A new event beats a clear in the same cycle
      assign next_status[b] = event_i[IDX] | (status_o[b] & ~clr_i[b]);
    end else begin : g_empty
      assign next_status[b] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= REG_WIDTH'(RST_WORD);
    end else begin
      status_o <= next_status;
    end
  end

  // Present whatever the gating setup is
  assign intr_summary_o = |(status_o & enable_i & ~mask_i);
  // Tied low when no field carries halt gating
  assign halt_summary_o = HAS_HALT &&
                          |(status_o & halt_en_i & ~halt_mask_i);

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Gating is judged in the cycle the bit is visible, so a control
  // write landing on the event edge cannot trip the check
  property p_intr_sum;
    event_i[0] ##1 (enable_i[P0] && !mask_i[P0]) |-> intr_summary_o;
  endproperty
  a_intr_sum: assert property (p_intr_sum)
    else $error("interrupt summary missed an enabled event");

  property p_halt_sum;
    HAS_HALT && event_i[0] ##1 (halt_en_i[P0] && !halt_mask_i[P0])
      |-> halt_summary_o;
  endproperty
  a_halt_sum: assert property (p_halt_sum)
    else $error("halt summary missed a halt-enabled event");

  property p_no_halt;
    !HAS_HALT |-> !halt_summary_o;
  endproperty
  a_no_halt: assert property (p_no_halt)
    else $error("halt summary driven without halt gating");

  property p_placement;
    event_i[0] |=> status_o[P0] ##1 (status_o[P0] || $past(clr_i[P0]));
  endproperty
  a_placement: assert property (p_placement)
    else $error("first field not at its packed position");

  c_intr: cover property (event_i[0] ##1 intr_summary_o);
endmodule

// ===== rtl/ext_reg_port.sv
// Purpose: Forwards one access to an externally built register.
// Assumes: External logic runs on clk_i and answers with ack or err.
// Notes:   err wins if ack and err come in the same cycle.
`timescale 1ns/1ns
module ext_reg_port (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  ext_link_if.port                           lnk,
  output logic                               ext_req_o,
  output logic                               ext_we_o,
  output logic      [regblk_pkg::ADDR_W-1:0] ext_addr_o,
  output logic      [regblk_pkg::SEL_W-1:0]  ext_sel_o,
  output logic      [regblk_pkg::DATA_W-1:0] ext_wdata_o,
  input  wire logic [regblk_pkg::DATA_W-1:0] ext_rdata_i,
  input  wire logic                          ext_ack_i,
  input  wire logic                          ext_err_i
);
  import regblk_pkg::*;

  logic              next_req, next_we, next_done, next_err;
  logic [ADDR_W-1:0] next_addr;
  logic [SEL_W-1:0]  next_sel;
  logic [DATA_W-1:0] next_wdata, next_rdata;

  always_comb begin
    next_req   = ext_req_o;
    next_we    = ext_we_o;
    next_addr  = ext_addr_o;
    next_sel   = ext_sel_o;
    next_wdata = ext_wdata_o;
    next_done  = 1'b0;
    next_err   = lnk.err;
    next_rdata = lnk.rdata;
    if (ext_req_o) begin
      if (ext_ack_i || ext_err_i) begin
        next_req   = 1'b0;
        next_done  = 1'b1;
        next_err   = ext_err_i;
        next_rdata = ext_rdata_i;
      end
    end else if (lnk.req) begin
      next_req   = 1'b1;
      next_we    = lnk.we;
      next_addr  = lnk.addr;
      next_sel   = lnk.sel;
      next_wdata = lnk.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_req_o   <= 1'b0;
      ext_we_o    <= 1'b0;
      ext_addr_o  <= '0;
      ext_sel_o   <= '0;
      ext_wdata_o <= '0;
      lnk.done    <= 1'b0;
      lnk.err     <= 1'b0;
      lnk.rdata   <= '0;
    end else begin
      ext_req_o   <= next_req;
      ext_we_o    <= next_we;
      ext_addr_o  <= next_addr;
      ext_sel_o   <= next_sel;
      ext_wdata_o <= next_wdata;
      lnk.done    <= next_done;
      lnk.err     <= next_err;
      lnk.rdata   <= next_rdata;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ext_err;
    ext_req_o && ext_err_i |=> lnk.done && lnk.err && !ext_req_o;
  endproperty
  a_ext_err: assert property (p_ext_err)
    else $error("external error not passed back");
endmodule

// ===== bench/ext_reg_model.sv
// Purpose: Behavioural stand-in for an externally built register.
// Assumes: Same clock as the block; one request at a time.
// Notes:   ERR_ADDR always ends in error; idle read data keeps toggling.
`timescale 1ns/1ns
module ext_reg_model #(
  parameter logic [7:0] ERR_ADDR = 8'hfc
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  slow_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o,
  output logic             ack_o,
  output logic             err_o
);
  logic [31:0] mem [32];
  logic [3:0]  wait_cnt;

  // Toggling data outside an answer so a stale sample never matches
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      wait_cnt <= 4'h0;
      rdata_o <= 32'h0;
    end else if (req_i && !ack_o && !err_o) begin
      if (wait_cnt == slow_i) begin
        wait_cnt <= 4'h0;
        err_o <= (addr_i == ERR_ADDR);
        ack_o <= (addr_i != ERR_ADDR);
        rdata_o <= mem[addr_i[6:2]];
        if (we_i && addr_i != ERR_ADDR)
          mem[addr_i[6:2]] <= wdata_i;
      end else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// ===== bench/register_subword_intr_summary_tb_top.sv
// Purpose: Self-checking bench of the interrupt register block.
// Assumes: Default parameters: 32-bit register, whole-word writes.
// Notes:   Table rows first, then summaries, reset and a slow partner.
`timescale 1ns/1ns
module register_subword_intr_summary_tb_top;
  import regblk_pkg::*;
  typedef struct packed {
    logic w; logic [7:0] a; logic [3:0] s; logic [31:0] d;
    logic e; logic [31:0] r; logic c;
  } row_t;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0, event_i = 0, eaddr;
  logic [3:0] sel = 0, slow = 0, esel;
  logic [31:0] dat = 0, dat_o, ewd, erd, q, dat2, q2;
  logic ack_o, err_o, intr, halt, ereq, ewe, eack, eerr, e, halt2;
  int error_cnt = 0, checked = 0;
  row_t rows [16];

  always #20 clk_i = ~clk_i;

  register_subword_intr_summary dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .event_i(event_i), .intr_summary_o(intr), .halt_summary_o(halt),
    .ext_req_o(ereq), .ext_we_o(ewe), .ext_addr_o(eaddr), .ext_sel_o(esel),
    .ext_wdata_o(ewd), .ext_rdata_i(erd), .ext_ack_i(eack),
    .ext_err_i(eerr));
  // Second build: high bit first, no halt gating; it runs in step with
  // the first one, so it shares the bus and the partner's answers
  register_subword_intr_summary #(.HIGH_FIRST(1'b1), .HAS_HALT(1'b0))
    dut2_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat2),
    .ack_o(), .err_o(), .event_i(event_i), .intr_summary_o(),
    .halt_summary_o(halt2), .ext_req_o(), .ext_we_o(), .ext_addr_o(),
    .ext_sel_o(), .ext_wdata_o(), .ext_rdata_i(erd), .ext_ack_i(eack),
    .ext_err_i(eerr));
  ext_reg_model ext_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .req_i(ereq), .we_i(ewe), .addr_i(eaddr), .wdata_i(ewd),
    .rdata_o(erd), .ack_o(eack), .err_o(eerr));

  task automatic chk_word(string n, logic [31:0] x, logic [31:0] g);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_bit(string n, logic x, logic g);
    chk_word(n, {31'h0, x}, {31'h0, g});
  endtask

  // Classic cycle: hold everything until ack or err is sampled high
  task automatic wb(logic w, logic [7:0] a, logic [3:0] s,
                    logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= s; dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 100);
    q = dat_o;
    q2 = dat2;
    e = err_o;
    cyc <= 0; stb <= 0; we <= 0;
    if (n >= 100) error_cnt++;
  endtask
  task automatic pulse(logic [7:0] ev);
    @(posedge clk_i);
    event_i <= ev;
    @(posedge clk_i);
    event_i <= 8'h0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    error_cnt++;
    test_done();
  end

  initial begin
    rows = '{
      '{1, OFF_ENABLE, 4'hf, 32'hff, 0, 0, 0},
      '{0, OFF_ENABLE, 4'h1, 0, 0, 32'hff, 1},
      '{1, OFF_MASK, 4'hf, 32'h0e, 0, 0, 0},
      '{0, OFF_MASK, 4'h2, 0, 0, 32'h0e, 1},
      '{1, OFF_MASK, 4'h0, 32'hff, 0, 0, 0},
      '{0, OFF_MASK, 4'hf, 0, 0, 32'h0e, 1},
      '{1, OFF_ENABLE, 4'h3, 32'h0, 1, 0, 0},
      '{0, OFF_ENABLE, 4'hf, 0, 0, 32'hff, 1},
      '{1, OFF_INFO, 4'hf, 32'h1, 1, 0, 0},
      '{0, 8'h40, 4'hf, 0, 1, 0, 0},
      '{1, OFF_HALT_EN, 4'hf, 32'hf1, 0, 0, 0},
      '{1, OFF_HALT_MASK, 4'hf, 32'h30, 0, 0, 0},
      '{1, 8'h84, 4'hf, 32'h5a3c_0f96, 0, 0, 0},
      '{0, 8'h84, 4'hf, 0, 0, 32'h5a3c_0f96, 1},
      '{0, 8'hfc, 4'hf, 0, 1, 0, 0},
      '{0, OFF_STATUS, 4'hf, 0, 0, 32'h0, 1}};
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].s, rows[i].d);
      chk_bit("err", rows[i].e, e);
      if (rows[i].c) chk_word("rdata", rows[i].r, q);
    end
    pulse(8'h04);
    chk_bit("intr masked", 0, intr);
    wb(0, OFF_STATUS, 4'hf, 0);
    chk_word("status", 32'h04, q);
    chk_word("status high first", 32'h2000_0000, q2);
    pulse(8'h20);
    chk_bit("intr", 1, intr);
    chk_bit("halt masked", 0, halt);
    pulse(8'h81);
    chk_bit("halt", 1, halt);
    chk_bit("halt absent", 1'b0, halt2);
    wb(1, OFF_STATUS, 4'hf, 32'ha5);
    wb(0, OFF_STATUS, 4'hf, 0);
    chk_word("status clr", 32'h0, q);
    chk_bit("intr clr", 0, intr);
    chk_bit("halt clr", 0, halt);
    pulse(8'h20);
    @(posedge clk_i);
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    #1;
    chk_bit("intr rst", 0, intr);
    wb(0, OFF_ENABLE, 4'hf, 0);
    chk_word("enable rst", RST_CTRL, q);
    slow <= 4'h3;
    wb(1, 8'h88, 4'hf, 32'h1234_abcd);
    chk_word("ext sel", 32'hf, {28'h0, esel});
    chk_word("ext addr", 32'h88, {24'h0, eaddr});
    wb(0, 8'h88, 4'hf, 0);
    chk_word("slow ext", 32'h1234_abcd, q);
    test_done();
  end
endmodule
